// file: logic/ptac_checker.sv
// Page table access checker: classifies accesses, fetches table entries, grants or traps.
// Assumes an APB master, a word memory read port for entries and one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "ptac_map.svh"

// Functional notes
// (RQ1) Addresses 0000_0000h..1FEF_FFFFh form the low region.
// (RQ2) Attached DRAM and the 1FFx_xxxxh window form the ram-and-io region.
// (RQ3) 2000_0000h..7FFF_FFFFh outside packet and instruction memory is the local-bus region.
// (RQ4) 8000_0000h..FFFF_FFFFh is the upper region.
// (RQ5) Each of the four regions has its own enable bit.
// (RQ6) Low region uses no tables; enabled, every access in it traps.
// (RQ7) Processor accesses below 0000_0400h are never checked.
// (RQ8) Processor 1FF0_0000..1FFF_FFFF checked under task, ram-and-io, read-check.
// (RQ9) Packet and instruction memory end at installed size; ram-and-io enables apply.
// (RQ10) Other processor local-bus addresses use task, local-bus, read-check enables.
// (RQ11) Upper space under upper enable; A000_0000 window uses ram-and-io with data cache.
// (RQ12) Bus masters: low range check, IO never, memories via master and read-check.
// (RQ13) Software aligns every page table to 64 bytes.
// (RQ14) One 32-bit entry covers 64KB as sixteen 4KB pages.
// (RQ15) Page bit pair write/read: 00 none, 01 read, 10 write, 11 both.
// (RQ16) A violation raises an event and latches the address per party.
// (RQ17) A violating write is blocked.
// (RQ18) Processor local-bus cycles start only when protection permits.
// (RQ19) Task table starts at 1FF0_0000h, slave table at 2000_0000h, 64KB steps.
// (RQ20) Entry is found from the table base indexed by address bits 31..16.
// (RQ21) Enable bits: ram-and-io 7, upper 6, read 5, lbus 4, slave 3, task 1, low 0.
// (RQ22) Upper 16 write bits mask the lower 16; mask reads back zero.
// (RQ23) Protection applies only when every relevant enable is active.
// (RQ24) Page n uses bit 2n+1 for write and bit 2n for read.
module ptac_checker
    import ptac_pkg::*;
#(
    parameter logic [31:0] MEM_BYTES = `PTAC_MEM_BYTES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Access to be checked
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic        acc_party,
    input  wire logic        acc_dcache,
    output logic             acc_ready,
    output logic             acc_done,
    output logic             acc_allow,
    output logic             acc_write_block,
    output logic             lb_cycle_start,
    output logic             prot_violation,
    // Page table entry read port
    output logic             pte_req,
    output logic [31:0]      pte_addr,
    input  wire logic        pte_valid,
    input  wire logic [31:0] pte_data
);

    // Installed memory must be a power of two between 64KB and the 32MB slot
    generate
        if (MEM_BYTES < 32'h00010000 || MEM_BYTES > 32'h02000000 ||
            (MEM_BYTES & (MEM_BYTES - 32'h1)) != 32'h0) begin : g_bad_mem
            $error("ptac_checker: MEM_BYTES unsupported");
        end
    endgenerate

    // Region of an address for a given party
    function automatic ptac_region_t classify(input logic [31:0] a, input logic bus,
                                              input logic dc);
        logic mem;
        mem = (a >= `PTAC_PKT_START && a < `PTAC_PKT_START + MEM_BYTES) ||
              (a >= `PTAC_INS_START && a < `PTAC_INS_START + MEM_BYTES); // see (RQ9)
        if (!bus && a <= `PTAC_INT_RAM_TOP)
            classify = PTAC_RG_NONE; // see (RQ7)
        else if (a <= `PTAC_LOW_TOP)
            classify = PTAC_RG_LOW; // see (RQ1)
        else if (a <= `PTAC_IO_TOP)
            classify = bus ? PTAC_RG_NONE : PTAC_RG_IO; // see (RQ2) see (RQ8) see (RQ12)
        else if (mem)
            classify = PTAC_RG_MEM;
        else if (a <= `PTAC_LBUS_TOP)
            classify = bus ? PTAC_RG_NONE : PTAC_RG_LBUS; // see (RQ3)
        else if (dc && a >= `PTAC_DCACHE_START && a <= `PTAC_DCACHE_TOP)
            classify = bus ? PTAC_RG_NONE : PTAC_RG_DCACHE; // see (RQ11)
        else
            classify = bus ? PTAC_RG_NONE : PTAC_RG_UPPER; // see (RQ4)
    endfunction

    // Page permission from an entry, page n on bits 2n+1 (write) and 2n (read)
    function automatic logic perm_ok(input logic [31:0] e, input logic [31:0] a,
                                     input logic wr);
        perm_ok = wr ? e[{a[15:12], 1'b1}] : e[{a[15:12], 1'b0}]; // see (RQ15) see (RQ24)
    endfunction

    // Register state
    logic [7:0]   en_reg;
    logic [7:0]   en_next;
    logic [31:6]  tbase_reg;
    logic [31:6]  tbase_next;
    logic [31:6]  sbase_reg;
    logic [31:6]  sbase_next;
    logic [31:0]  ttrap_reg;
    logic [31:0]  ttrap_next;
    logic [31:0]  btrap_reg;
    logic [31:0]  btrap_next;
    logic [31:0]  prdata_reg;
    logic [31:0]  prdata_next;
    // Checker state
    ptac_state_t  state_reg;
    ptac_state_t  state_next;
    logic [31:0]  addr_reg;
    logic [31:0]  addr_next;
    logic         wr_reg;
    logic         wr_next;
    logic         bus_reg;
    logic         bus_next;
    logic         allow_reg;
    logic         allow_next;
    logic         lbs_reg;
    logic         lbs_next;
    logic [31:0]  pte_addr_reg;
    logic [31:0]  pte_addr_next;

    // Decode of the incoming access
    ptac_region_t rg_now;
    logic         guard_now;
    logic         lookup_now;
    logic [15:0]  idx_now;
    logic         is_bus;
    logic         chk_rd;
    logic         apb_wr;
    logic         apb_setup;
    logic         mapped;
    logic [15:0]  mask;
    logic         lb_target;

    assign is_bus    = (acc_party == PTAC_PARTY_BUS);
    assign rg_now    = classify(acc_addr, is_bus, acc_dcache);
    assign chk_rd    = acc_write | en_reg[`PTAC_EN_RDCHK];
    assign apb_wr    = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign mask      = pwdata[31:16];
    assign mapped    = (paddr == `PTAC_OFS_ENABLE) || (paddr == `PTAC_OFS_TASK_BASE) ||
                       (paddr == `PTAC_OFS_SLAVE_BASE) || (paddr == `PTAC_OFS_TASK_TRAP) ||
                       (paddr == `PTAC_OFS_BUS_TRAP);
    assign lb_target = (acc_addr >= `PTAC_PKT_START) && (acc_addr <= `PTAC_LBUS_TOP);

    // Protection guard: every relevant enable must be on
    always_comb begin
        guard_now  = 1'b0;
        lookup_now = 1'b0;
        idx_now    = acc_addr[31:16] - `PTAC_TASK_FIRST; // see (RQ19)
        if (is_bus) begin
            idx_now = acc_addr[31:16] - `PTAC_SLAVE_FIRST; // see (RQ19)
            unique case (rg_now)
                PTAC_RG_LOW: guard_now = en_reg[`PTAC_EN_SLAVE] & en_reg[`PTAC_EN_LOW];
                PTAC_RG_MEM: begin
                    guard_now  = en_reg[`PTAC_EN_SLAVE] & chk_rd; // see (RQ12)
                    lookup_now = 1'b1;
                end
                default: guard_now = 1'b0;
            endcase
        end else begin
            unique case (rg_now)
                PTAC_RG_LOW: guard_now = en_reg[`PTAC_EN_TASK] & en_reg[`PTAC_EN_LOW];
                PTAC_RG_IO, PTAC_RG_MEM, PTAC_RG_DCACHE: begin
                    guard_now  = en_reg[`PTAC_EN_TASK] & en_reg[`PTAC_EN_RAM_IO_REGION_ENABLE] & chk_rd;
                    lookup_now = 1'b1;
                end
                PTAC_RG_LBUS:
                    guard_now = en_reg[`PTAC_EN_TASK] & en_reg[`PTAC_EN_LBUS] & chk_rd;
                PTAC_RG_UPPER: guard_now = en_reg[`PTAC_EN_TASK] & en_reg[`PTAC_EN_UPPER];
                default: guard_now = 1'b0;
            endcase
        end
    end

    // Register file next values; trap capture belongs to the checker below
    always_comb begin
        en_next     = en_reg;
        tbase_next  = tbase_reg;
        sbase_next  = sbase_reg;
        prdata_next = prdata_reg;
        // Only a full-word write with the write-enable bit set counts
        if (apb_wr && paddr == `PTAC_OFS_ENABLE && pstrb == 4'hF && pwdata[`PTAC_EN_WRT])
            en_next = ((en_reg & ~mask[7:0]) | (pwdata[7:0] & mask[7:0])) &
                      `PTAC_EN_IMPL; // see (RQ22) see (RQ5)
        if (apb_wr && paddr == `PTAC_OFS_TASK_BASE)
            tbase_next = pwdata[31:6]; // see (RQ13)
        if (apb_wr && paddr == `PTAC_OFS_SLAVE_BASE)
            sbase_next = pwdata[31:6];
        // Read data captured in setup so it comes from a flop in the access phase
        if (apb_setup) begin
            unique case (paddr)
                `PTAC_OFS_ENABLE:     prdata_next = {24'h000000, en_reg}; // see (RQ21)
                `PTAC_OFS_TASK_BASE:  prdata_next = {tbase_reg, 6'h00};
                `PTAC_OFS_SLAVE_BASE: prdata_next = {sbase_reg, 6'h00};
                `PTAC_OFS_TASK_TRAP:  prdata_next = ttrap_reg;
                `PTAC_OFS_BUS_TRAP:   prdata_next = btrap_reg;
                default:              prdata_next = 32'h00000000;
            endcase
        end
    end

    // Checker sequence: take, optionally fetch the entry, then report one cycle
    always_comb begin
        state_next    = state_reg;
        addr_next     = addr_reg;
        wr_next       = wr_reg;
        bus_next      = bus_reg;
        allow_next    = allow_reg;
        lbs_next      = lbs_reg;
        pte_addr_next = pte_addr_reg;
        ttrap_next    = ttrap_reg;
        btrap_next    = btrap_reg;
        unique case (state_reg)
            PTAC_ST_IDLE: begin
                if (acc_valid) begin
                    addr_next = acc_addr;
                    wr_next   = acc_write;
                    bus_next  = is_bus;
                    lbs_next  = ~is_bus & lb_target;
                    if (!guard_now) begin
                        allow_next = 1'b1; // see (RQ23)
                        state_next = PTAC_ST_RESULT;
                    end else if (lookup_now) begin
                        pte_addr_next = {is_bus ? sbase_reg : tbase_reg, 6'h00} +
                                        {14'h0000, idx_now, 2'b00}; // see (RQ20) see (RQ14)
                        state_next    = PTAC_ST_FETCH;
                    end else begin
                        allow_next = 1'b0; // see (RQ6) see (RQ10)
                        state_next = PTAC_ST_RESULT;
                    end
                end
            end
            PTAC_ST_FETCH: begin
                if (pte_valid) begin
                    allow_next = perm_ok(pte_data, addr_reg, wr_reg); // see (RQ15)
                    state_next = PTAC_ST_RESULT;
                end
            end
            PTAC_ST_RESULT: begin
                state_next = PTAC_ST_IDLE;
                // Denied access leaves its address in the party's trap register
                if (!allow_reg) begin
                    if (bus_reg)
                        btrap_next = addr_reg; // see (RQ16)
                    else
                        ttrap_next = addr_reg; // see (RQ16)
                end
            end
            default: state_next = PTAC_ST_IDLE; // Unused fourth code recovers to idle
        endcase
    end

    // All state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg       <= `PTAC_EN_RESET;
            tbase_reg    <= `PTAC_BASE_RESET;
            sbase_reg    <= `PTAC_BASE_RESET;
            ttrap_reg    <= `PTAC_TRAP_RESET;
            btrap_reg    <= `PTAC_TRAP_RESET;
            prdata_reg   <= 32'h00000000;
            state_reg    <= PTAC_ST_IDLE;
            addr_reg     <= 32'h00000000;
            wr_reg       <= 1'b0;
            bus_reg      <= 1'b0;
            allow_reg    <= 1'b0;
            lbs_reg      <= 1'b0;
            pte_addr_reg <= 32'h00000000;
        end else begin
            en_reg       <= en_next;
            tbase_reg    <= tbase_next;
            sbase_reg    <= sbase_next;
            ttrap_reg    <= ttrap_next;
            btrap_reg    <= btrap_next;
            prdata_reg   <= prdata_next;
            state_reg    <= state_next;
            addr_reg     <= addr_next;
            wr_reg       <= wr_next;
            bus_reg      <= bus_next;
            allow_reg    <= allow_next;
            lbs_reg      <= lbs_next;
            pte_addr_reg <= pte_addr_next;
        end
    end

    // Outputs; zero-wait slave, unmapped offsets answer with an error
    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~mapped;
    assign prdata          = prdata_reg;
    assign acc_ready       = (state_reg == PTAC_ST_IDLE);
    assign acc_done        = (state_reg == PTAC_ST_RESULT);
    assign acc_allow       = acc_done & allow_reg;
    assign acc_write_block = acc_done & ~allow_reg & wr_reg; // see (RQ17)
    assign prot_violation  = acc_done & ~allow_reg; // see (RQ16)
    assign lb_cycle_start  = acc_done & allow_reg & lbs_reg; // see (RQ18)
    assign pte_req         = (state_reg == PTAC_ST_FETCH);
    assign pte_addr        = pte_addr_reg;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take_cpu;
        acc_ready && acc_valid && !is_bus;
    endsequence

    property p_low_trap;
        s_take_cpu and (rg_now == PTAC_RG_LOW) and en_reg[0] and en_reg[1]
            |=> acc_done && prot_violation;
    endproperty
    a_low_trap: assert property (p_low_trap) else $error("low region not trapped"); // see (RQ6)

    property p_int_ram;
        s_take_cpu and (acc_addr <= `PTAC_INT_RAM_TOP) |=> acc_allow;
    endproperty
    a_int_ram: assert property (p_int_ram) else $error("internal RAM checked"); // see (RQ7)

    property p_upper;
        s_take_cpu and (rg_now == PTAC_RG_UPPER) and en_reg[6] and en_reg[1]
            |=> prot_violation;
    endproperty
    a_upper: assert property (p_upper) else $error("upper region not trapped"); // see (RQ4)

    property p_off;
        s_take_cpu and !en_reg[1] |=> acc_allow;
    endproperty
    a_off: assert property (p_off) else $error("check without task enable"); // see (RQ23)

    property p_fetch_addr;
        acc_ready && acc_valid && guard_now && lookup_now && is_bus
            |=> pte_req && pte_addr == {$past(sbase_reg), 6'h00} + {$past(acc_addr[31:16])
                - 16'h2000, 2'b00};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("bad entry address"); // see (RQ20)

    property p_wr_block;
        prot_violation && wr_reg |-> acc_write_block && !acc_allow;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write not blocked"); // see (RQ17)

    property p_lb_gate;
        lb_cycle_start |-> acc_allow && !prot_violation;
    endproperty
    a_lb_gate: assert property (p_lb_gate) else $error("local-bus cycle not gated"); // see (RQ18)

    property p_trap;
        prot_violation && !bus_reg |=> ttrap_reg == $past(addr_reg) && acc_ready;
    endproperty
    a_trap: assert property (p_trap) else $error("trap address lost"); // see (RQ16)

    property p_mask;
        apb_wr && paddr == `PTAC_OFS_ENABLE
            |=> ((en_reg ^ $past(en_reg)) & ~$past(mask[7:0])) == 8'h00;
    endproperty
    a_mask: assert property (p_mask) else $error("unmasked enable bit changed"); // see (RQ22)

endmodule // ptac_checker
`default_nettype wire

// file: logic/ptac_map.svh
// Offsets, field positions, reset values and address bounds of the page table access checker.
// Assumes a 12-bit APB byte address seen by the block.
`ifndef PTAC_MAP_SVH
`define PTAC_MAP_SVH

// Register byte offsets
`define PTAC_OFS_ENABLE     12'h000
`define PTAC_OFS_TASK_BASE  12'h004
`define PTAC_OFS_SLAVE_BASE 12'h008
`define PTAC_OFS_TASK_TRAP  12'h00C
`define PTAC_OFS_BUS_TRAP   12'h010

// Enable register bit positions
`define PTAC_EN_LOW    0
`define PTAC_EN_TASK   1
`define PTAC_EN_SLAVE  3
`define PTAC_EN_LBUS   4
`define PTAC_EN_RDCHK  5
`define PTAC_EN_UPPER  6
`define PTAC_EN_RAM_IO_REGION_ENABLE  7
`define PTAC_EN_WRT    15
`define PTAC_EN_IMPL   8'hFB
`define PTAC_EN_RESET  8'h00
`define PTAC_BASE_RESET 26'h0000000
`define PTAC_TRAP_RESET 32'h00000000

// Address bounds
`define PTAC_INT_RAM_TOP  32'h000003FF
`define PTAC_LOW_TOP      32'h1FEFFFFF
`define PTAC_IO_TOP       32'h1FFFFFFF
`define PTAC_PKT_START    32'h20000000
`define PTAC_INS_START    32'h22000000
`define PTAC_LBUS_TOP     32'h7FFFFFFF
`define PTAC_DCACHE_START 32'hA0000000
`define PTAC_DCACHE_TOP   32'hAFFFFFFF
`define PTAC_TASK_FIRST   16'h1FF0
`define PTAC_SLAVE_FIRST  16'h2000
`define PTAC_MEM_BYTES    32'h02000000

`endif

// file: logic/ptac_pkg.sv
// Types shared by the page table access checker.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ptac_pkg;
    typedef enum logic {PTAC_PARTY_CPU, PTAC_PARTY_BUS} ptac_party_t;
    typedef enum logic [2:0] {
        PTAC_RG_NONE, PTAC_RG_LOW, PTAC_RG_IO, PTAC_RG_MEM,
        PTAC_RG_LBUS, PTAC_RG_UPPER, PTAC_RG_DCACHE
    } ptac_region_t;
    typedef enum logic [1:0] {PTAC_ST_IDLE, PTAC_ST_FETCH, PTAC_ST_RESULT} ptac_state_t;
endpackage
`default_nettype wire

// file: testbench/page_table_access_checker_tb_top.sv
// Self-checking bench for the page table access checker with a reference model.
// Assumes ptac_pte_mem answers entry fetches; the design files compile first.
`timescale 1ns/10ps
`default_nettype none
`include "ptac_map.svh"
module page_table_access_checker_tb_top;
    localparam logic [31:0] MEMB = 32'h0200_0000;
    // Design signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, acc_addr, pte_addr, pte_data;
    logic [3:0]  pstrb;
    logic        acc_valid, acc_write, acc_party, acc_dcache, acc_ready, acc_done;
    logic        acc_allow, acc_write_block, lb_cycle_start, prot_violation;
    logic        pte_req, pte_valid;
    // Bench state
    int          n_fail, checked, seed, i, j;
    logic [7:0]  en;
    logic [31:0] tb_base, sb_base, rdat, r;
    logic        rerr;
    logic [31:0] edges [16] = '{32'h0000_03FF, 32'h0000_0400, 32'h1FEF_FFFF, 32'h1FF0_0000,
        32'h1FFF_FFFF, 32'h2000_0000, 32'h21FF_FFFF, 32'h23FF_FFFF, 32'h2400_0000,
        32'h7FFF_FFFF, 32'h8000_0000, 32'h9FFF_FFFF, 32'hA000_0000, 32'hAFFF_FFFF,
        32'hB000_0000, 32'hFFFF_FFFF};
    logic [31:0] rbase [9] = '{32'h0, 32'h1000_0000, 32'h1FF0_0000, 32'h2000_0000,
        32'h2200_0000, 32'h2400_0000, 32'h8000_0000, 32'hA000_0000, 32'hB000_0000};
    logic [31:0] rmask [9] = '{32'h3FF, 32'h0FEF_FFFF, 32'h000F_FFFF, 32'h01FF_FFFF,
        32'h01FF_FFFF, 32'h3BFF_FFFF, 32'h1FFF_FFFF, 32'h0FFF_FFFF, 32'h4FFF_FFFF};

    ptac_checker #(.MEM_BYTES(MEMB)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .acc_valid, .acc_addr,
        .acc_write, .acc_party, .acc_dcache, .acc_ready, .acc_done, .acc_allow,
        .acc_write_block, .lb_cycle_start, .prot_violation, .pte_req, .pte_addr,
        .pte_valid, .pte_data);
    ptac_pte_mem pmem (.pclk, .presetn, .pte_req, .pte_addr, .pte_valid, .pte_data);

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test;
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            stop_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee,
                          input string what);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(what, e, rdat);
        chk1("pslverr", ee, rerr);
    endtask

    task automatic set_en(input logic [7:0] m, input logic [7:0] v, input logic [3:0] s,
                          input logic we);
        apb(1'b1, `PTAC_OFS_ENABLE, {8'h00, m, we, 7'h00, v}, s);
        if (we && s == 4'hF) en = ((en & ~m) | (v & m)) & 8'hFB;
        rd_chk(`PTAC_OFS_ENABLE, {24'h0, en}, 1'b0, "enable");
    endtask

    function automatic logic inmem(input logic [31:0] a);
        return (a >= 32'h2000_0000 && a < 32'h2000_0000 + MEMB) ||
               (a >= 32'h2200_0000 && a < 32'h2200_0000 + MEMB);
    endfunction

    // Reference model plus one checked access
    task automatic access(input logic [31:0] a, input logic w, input logic p, input logic dc);
        logic lk, tr, ok, seen, rc;
        logic [31:0] ea, e;
        int n;
        lk = 1'b0;
        tr = 1'b0;
        ea = 32'h0;
        rc = w | en[5];
        if (!p) begin
            if (a <= 32'h0000_03FF) tr = 1'b0;
            else if (a <= 32'h1FEF_FFFF) tr = en[1] & en[0];
            else if (a <= 32'h1FFF_FFFF || inmem(a) || (dc && a[31:28] == 4'hA)) begin
                lk = en[1] & en[7] & rc;
                ea = tb_base + {14'h0, 16'(a[31:16] - 16'h1FF0), 2'b00};
            end
            else if (a <= 32'h7FFF_FFFF) tr = en[1] & en[4] & rc;
            else tr = en[1] & en[6];
        end else begin
            if (a <= 32'h1FEF_FFFF) tr = en[3] & en[0];
            else if (inmem(a)) begin
                lk = en[3] & rc;
                ea = sb_base + {14'h0, 16'(a[31:16] - 16'h2000), 2'b00};
            end
        end
        e = $random(seed);
        if (lk) pmem.mem[ea] = e;
        ok = lk ? e[{a[15:12], w}] : !tr;
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_write <= w;
        acc_party <= p;
        acc_dcache <= dc;
        n = 0;
        seen = 1'b0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 1) chk1("ready", 1'b1, acc_ready);
            if (pte_req === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("pte_addr", ea, pte_addr);
            end
        end while (acc_done !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_fail++;
            stop_test();
        end
        acc_valid <= 1'b0;
        chk1("fetch", lk, seen);
        chk1("ready", 1'b0, acc_ready);
        if (!lk) chk("latency", 32'd2, 32'(n));
        chk1("allow", ok, acc_allow);
        chk1("violation", !ok, prot_violation);
        chk1("write_block", !ok && w, acc_write_block);
        chk1("lb_start", ok && !p && a >= 32'h2000_0000 && a <= 32'h7FFF_FFFF,
             lb_cycle_start);
        if (!ok) rd_chk(p ? `PTAC_OFS_BUS_TRAP : `PTAC_OFS_TASK_TRAP, a, 1'b0, "trap");
    endtask

    initial begin
        {presetn, psel, penable, pwrite, acc_valid, acc_write, acc_party, acc_dcache} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        acc_addr = 32'h0;
        n_fail = 0;
        checked = 0;
        seed = 32'he379;
        en = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) rd_chk(12'(4 * i), 32'h0, 1'b0, "reset value");
        rd_chk(12'h014, 32'h0, 1'b1, "unmapped");
        // Bases keep only 64-byte aligned pointers
        apb(1'b1, `PTAC_OFS_TASK_BASE, 32'h2280_007F, 4'hF);
        tb_base = 32'h2280_0040;
        rd_chk(`PTAC_OFS_TASK_BASE, tb_base, 1'b0, "task base");
        apb(1'b1, `PTAC_OFS_SLAVE_BASE, 32'h2000_0415, 4'hF);
        sb_base = 32'h2000_0400;
        rd_chk(`PTAC_OFS_SLAVE_BASE, sb_base, 1'b0, "slave base");
        apb(1'b1, `PTAC_OFS_TASK_TRAP, 32'hFFFF_FFFF, 4'hF);
        rd_chk(`PTAC_OFS_TASK_TRAP, 32'h0, 1'b0, "trap ro");
        set_en(8'h02, 8'h02, 4'hF, 1'b1);
        set_en(8'hFF, 8'hFF, 4'hF, 1'b0);
        set_en(8'hFF, 8'hFF, 4'h7, 1'b1);
        set_en(8'hFF, 8'hFF, 4'hF, 1'b1);
        // Region edges, every party, direction and cache setting
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 128; i++) access(edges[i / 8], i[0], i[1], i[2]);
            set_en(8'hFF, 8'h00, 4'hF, 1'b1);
        end
        // Random addresses under random enable sets
        for (i = 0; i < 240; i++) begin
            if (i % 8 == 0) set_en(8'($random(seed)), 8'($random(seed)), 4'hF, 1'b1);
            r = $random(seed);
            j = $unsigned($random(seed)) % 9;
            access(rbase[j] | (r & rmask[j]), r[31], r[30], r[29]);
        end
        // Reset in mid-run clears the enables
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`PTAC_OFS_ENABLE, 32'h0, 1'b0, "enable after reset");
        rd_chk(`PTAC_OFS_TASK_TRAP, 32'h0, 1'b0, "trap after reset");
        stop_test();
    end
endmodule // page_table_access_checker_tb_top
`default_nettype wire

// file: testbench/ptac_pte_mem.sv
// Table memory model answering entry fetches from the checker.
// Assumes one clock; the bench fills mem before each fetch it expects.
`timescale 1ns/10ps
`default_nettype none
module ptac_pte_mem (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Entry read port
    input  wire logic        pte_req,
    input  wire logic [31:0] pte_addr,
    output logic             pte_valid,
    output logic [31:0]      pte_data
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  wait_reg;
    logic [1:0]  dly_reg;
    logic [31:0] junk_reg;
    // Reply after 0..3 idle cycles in rotation, so prompt and slow answers both occur
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pte_valid <= 1'b0;
            pte_data  <= 32'h0000_0000;
            wait_reg  <= 2'h0;
            dly_reg   <= 2'h0;
            junk_reg  <= 32'h5A5A_0F0F;
        end else begin
            pte_valid <= 1'b0;
            junk_reg  <= junk_reg + 32'h9E37_79B9;
            pte_data  <= ~junk_reg; // Data not held outside the valid cycle
            if (pte_req && !pte_valid) begin
                if (wait_reg == dly_reg) begin
                    pte_valid <= 1'b1;
                    pte_data  <= mem.exists(pte_addr) ? mem[pte_addr] : junk_reg;
                    wait_reg  <= 2'h0;
                    dly_reg   <= dly_reg + 2'h1;
                end else begin
                    wait_reg <= wait_reg + 2'h1;
                end
            end
        end
    end
endmodule // ptac_pte_mem
`default_nettype wire
